/* verif/lapc_periph.sv */
// Far-side model: pulled-up port A wires and external drivers of port D pins 1 and 2
`timescale 1ns/1ps
`default_nettype none
module lapc_periph (
    input wire logic mclk_in,
    input wire logic [7:0] pa_in,
    input wire logic [7:0] pa_oe_in,
    output logic [7:0] pa_wire_out,
    output logic [2:0] pd_pin_out
);
    // Released pins float up to the board pull-up
    assign pa_wire_out = (pa_in & pa_oe_in) | ~pa_oe_in;
    initial pd_pin_out = 3'h0;
    task automatic clk_pulse;
        @(posedge mclk_in);
        pd_pin_out[1] <= 1'b1;
        repeat (4) @(posedge mclk_in);
        pd_pin_out[1] <= 1'b0;
    endtask
    task automatic set_cs(input logic v);
        @(posedge mclk_in);
        pd_pin_out[2] <= v;
    endtask
endmodule
`default_nettype wire

/* verif/lapc_top_tb.sv */
// Register-level bench for the latched address port configuration block
`timescale 1ns/1ps
`default_nettype none
`include "lapc_consts.svh"
module lapc_top_tb
    import lapc_pkg::*;
;
    logic mclk_in = 1'b0, rst_in = 1'b1, rd = 1'b0, wr = 1'b0, ale = 1'b0, fsel = 1'b0;
    logic [7:0] adr = 8'h00, pa_pt = 8'h00, pb_pt = 8'h00, peri_oe = 8'h00, peri_d = 8'h00;
    logic [31:0] wd = 32'h0, rdata;
    logic [3:0] be = 4'h0;
    logic [15:0] mux_ad = 16'h0000;
    logic [2:0] pd_pt = 3'h0, pd_pin, pd_out, pd_oe, pd_fs;
    logic wreq, omc_clk, apd_wake, standby, fsel_out;
    logic [7:0] pa_out, pa_oe, pa_fs, pb_out, pb_oe, pb_fs, pa_wire;
    logic [31:0] q;
    int err_count = 0, n_tests = 0, n_clk = 0, n_apd = 0;
    initial forever #20 mclk_in = ~mclk_in;
    always @(posedge mclk_in)
    begin
        if (omc_clk === 1'b1) n_clk++;
        if (apd_wake === 1'b1) n_apd++;
    end
    lapc_top #(.PD_W(3)) DUT (.mclk_in(mclk_in), .rst_in(rst_in), .avs_address_in(adr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq), .mux_ad_in(mux_ad), .ale_in(ale), .pa_pt_oe_in(pa_pt), .pb_pt_oe_in(pb_pt),
        .pd_pt_oe_in(pd_pt), .pa_peri_oe_in(peri_oe), .pa_peri_data_in(peri_d), .pd_pin_in(pd_pin),
        .flash_select_in(fsel), .pa_out(pa_out), .pa_oe_out(pa_oe), .pa_fast_slew_out(pa_fs), .pb_out(pb_out),
        .pb_oe_out(pb_oe), .pb_fast_slew_out(pb_fs), .pd_out(pd_out), .pd_oe_out(pd_oe),
        .pd_fast_slew_out(pd_fs), .output_macrocell_clk_out(omc_clk), .auto_power_down_wake_out(apd_wake),
        .flash_standby_out(standby), .flash_select_out(fsel_out));
    lapc_periph periph (.mclk_in(mclk_in), .pa_in(pa_out), .pa_oe_in(pa_oe), .pa_wire_out(pa_wire),
        .pd_pin_out(pd_pin));
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    // Request held until the edge at which waitrequest is seen low
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
        int i;
        @(posedge mclk_in);
        adr <= a;
        wd <= d;
        be <= b;
        rd <= ~w;
        wr <= w;
        for (i = 0; i < 50; i++)
        begin
            @(posedge mclk_in);
            if (wreq === 1'b0) break;
        end
        if (i == 50)
        begin
            err_count++;
            report_and_stop();
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wreg(input logic [5:0] i, input logic [7:0] d);
        bus(1'b1, {i, 2'b00}, {24'h0, d}, 4'hf);
    endtask
    task automatic rchk(input logic [5:0] i, input logic [31:0] e);
        bus(1'b0, {i, 2'b00}, 32'h0, 4'hf);
        check(q, e);
    endtask
    task automatic settle;
        repeat (4) @(posedge mclk_in);
        @(negedge mclk_in);
    endtask
    // Address phase under the strobe, then the data phase on the same lines
    task automatic strobe(input logic [15:0] a);
        @(posedge mclk_in);
        mux_ad <= a;
        ale <= 1'b1;
        @(posedge mclk_in);
        ale <= 1'b0;
        mux_ad <= ~a;
        settle();
    endtask
    initial
    begin
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'b0;
        rchk(`LAPC_IDX_PA_LAE, 32'h0);
        rchk(`LAPC_IDX_PA_DRV, 32'h0);
        check({24'h0, pa_oe}, 32'h0);
        bus(1'b1, {`LAPC_IDX_PA_LAE, 2'b00}, 32'hff, 4'h0);
        bus(1'b1, {`LAPC_IDX_PA_LAE, 2'b01}, 32'hff, 4'hf);
        wreg(6'h3f, 8'hff);
        rchk(6'h3f, 32'h0);
        rchk(`LAPC_IDX_PA_LAE, 32'h0);
        $display("test 1 reset and refused accesses done");
        wreg(`LAPC_IDX_PA_LAE, 8'ha5);
        wreg(`LAPC_IDX_PB_LAE, 8'h3c);
        wreg(`LAPC_IDX_PB_HISEL, 8'h0f);
        wreg(`LAPC_IDX_PB_DATA, 8'h81);
        wreg(`LAPC_IDX_PB_DIR, 8'hc3);
        rchk(`LAPC_IDX_PA_LAE, 32'ha5);
        strobe(16'h5aa5);
        check({24'h0, pa_out}, 32'ha5);
        check({24'h0, pa_oe}, 32'ha5);
        check({24'h0, pb_out}, 32'ha9);
        check({24'h0, pb_oe}, 32'hff);
        rchk(`LAPC_IDX_LADDR, 32'ha5);
        strobe(16'h0f12);
        check({24'h0, pa_out}, 32'h00);
        check({24'h0, pb_out}, 32'h9d);
        settle();
        check({24'h0, pa_out}, 32'h00);
        $display("test 2 latched address done");
        wreg(`LAPC_IDX_PA_LAE, 8'h00);
        wreg(`LAPC_IDX_PA_DIR, 8'hff);
        wreg(`LAPC_IDX_PA_DATA, 8'ha0);
        wreg(`LAPC_IDX_PA_DRV, 8'hf3);
        wreg(`LAPC_IDX_PB_DRV, 8'h5a);
        settle();
        check({24'h0, pb_fs}, 32'h0a);
        check({24'h0, pa_fs}, 32'h03);
        check({24'h0, pa_oe}, 32'h5f);
        check({24'h0, pa_wire}, 32'ha0);
        rchk(`LAPC_IDX_PA_EO, 32'h5f);
        rchk(`LAPC_IDX_PA_DRV, 32'hf3);
        $display("test 3 drive select done");
        wreg(`LAPC_IDX_PA_DRV, 8'h00);
        wreg(`LAPC_IDX_PA_DIR, 8'hf0);
        wreg(`LAPC_IDX_PA_PTSEL, 8'h0f);
        wreg(`LAPC_IDX_PA_PERI, 8'hc0);
        pa_pt <= 8'h03;
        peri_oe <= 8'h40;
        peri_d <= 8'hff;
        settle();
        check({24'h0, pa_oe}, 32'h73);
        check({24'h0, pa_out & 8'hc0}, 32'hc0);
        rchk(`LAPC_IDX_PA_EO, 32'h73);
        $display("test 4 enable sources done");
        wreg(`LAPC_IDX_PD_DRV, 8'h07);
        wreg(`LAPC_IDX_PD_DIR, 8'h07);
        wreg(`LAPC_IDX_PD_FUNC, 8'h03);
        wreg(`LAPC_IDX_PD_DATA, 8'h05);
        fsel <= 1'b1;
        settle();
        check({29'h0, pd_out}, 32'h5);
        check({29'h0, pd_fs}, 32'h7);
        check({29'h0, pd_oe}, 32'h1);
        rchk(`LAPC_IDX_PD_EO, 32'h1);
        periph.clk_pulse();
        settle();
        check(n_clk, 32'h1);
        check(n_apd, 32'h1);
        periph.set_cs(1'b1);
        settle();
        check({30'h0, standby, fsel_out}, 32'h2);
        periph.set_cs(1'b0);
        settle();
        check({30'h0, standby, fsel_out}, 32'h1);
        wreg(`LAPC_IDX_PD_FUNC, 8'h00);
        periph.clk_pulse();
        periph.set_cs(1'b1);
        settle();
        check(n_clk, 32'h1);
        check({30'h0, standby, fsel_out}, 32'h1);
        $display("test 5 port D functions done");
        report_and_stop();
    end
endmodule
`default_nettype wire

/* verilog/lapc_addr_if.sv */
// Carrier between the address latch and the port logic
`timescale 1ns/1ps
`default_nettype none
interface lapc_addr_if;
    import lapc_pkg::*;
    lapc_addr_t mux_ad;
    logic ale;
    lapc_addr_t latched;
    modport latch (input mux_ad, input ale, output latched);
    modport user (output mux_ad, output ale, input latched);
endinterface
`default_nettype wire

/* verilog/lapc_addr_latch.sv */
// Address latch that splits address from the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module lapc_addr_latch
    import lapc_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    lapc_addr_if.latch bus
);
`include "lapc_consts.svh"

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            bus.latched <= `LAPC_ADDR_RST;
        else if (bus.ale)
            bus.latched <= bus.mux_ad;
    end

    hold_capture_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        (bus.ale ##1 !bus.ale [*2]) |-> bus.latched == $past(bus.mux_ad, 2))
        else $error("latched address not held after strobe");
endmodule
`default_nettype wire

/* verilog/lapc_consts.svh */
// Register word indexes, reset values and field positions of the port configuration block
`ifndef LAPC_CONSTS_SVH
`define LAPC_CONSTS_SVH
`define LAPC_ADDR_W 8
`define LAPC_IDX_W 6
`define LAPC_IDX_PA_LAE 6'h02
`define LAPC_IDX_PB_LAE 6'h03
`define LAPC_IDX_PB_HISEL 6'h04
`define LAPC_IDX_PA_DIR 6'h05
`define LAPC_IDX_PB_DIR 6'h06
`define LAPC_IDX_PD_DIR 6'h07
`define LAPC_IDX_PA_DRV 6'h08
`define LAPC_IDX_PB_DRV 6'h09
`define LAPC_IDX_PD_DRV 6'h0a
`define LAPC_IDX_PA_PTSEL 6'h0b
`define LAPC_IDX_PB_PTSEL 6'h0c
`define LAPC_IDX_PD_PTSEL 6'h0d
`define LAPC_IDX_PA_PERI 6'h0e
`define LAPC_IDX_PA_DATA 6'h10
`define LAPC_IDX_PB_DATA 6'h11
`define LAPC_IDX_PD_DATA 6'h12
`define LAPC_IDX_PA_EO 6'h14
`define LAPC_IDX_PB_EO 6'h15
`define LAPC_IDX_PD_EO 6'h16
`define LAPC_IDX_PD_FUNC 6'h17
`define LAPC_IDX_LADDR 6'h18
`define LAPC_REG_RST 8'h00
`define LAPC_ADDR_RST 16'h0000
`define LAPC_RD_ZERO 32'h0000_0000
`define LAPC_FUNC_CLK 0
`define LAPC_FUNC_CS 1
`define LAPC_PD_CLK_PIN 1
`define LAPC_PD_CS_PIN 2
`endif

/* verilog/lapc_pkg.sv */
// Types shared by the port configuration block
package lapc_pkg;
    typedef logic [7:0] lapc_byte_t;
    typedef logic [15:0] lapc_addr_t;
    typedef enum logic {LAPC_BUS_IDLE, LAPC_BUS_ACK} lapc_bus_t;
endpackage

/* verilog/lapc_top.sv */
// Latched address output on ports A and B, and pin drive configuration for ports A, B and D
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module lapc_top
    import lapc_pkg::*;
#(
    parameter int PD_W = 3
)
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [7:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic [15:0] mux_ad_in,
    input wire logic ale_in,
    input wire logic [7:0] pa_pt_oe_in,
    input wire logic [7:0] pb_pt_oe_in,
    input wire logic [PD_W-1:0] pd_pt_oe_in,
    input wire logic [7:0] pa_peri_oe_in,
    input wire logic [7:0] pa_peri_data_in,
    input wire logic [PD_W-1:0] pd_pin_in,
    input wire logic flash_select_in,
    output logic [7:0] pa_out,
    output logic [7:0] pa_oe_out,
    output logic [7:0] pa_fast_slew_out,
    output logic [7:0] pb_out,
    output logic [7:0] pb_oe_out,
    output logic [7:0] pb_fast_slew_out,
    output logic [PD_W-1:0] pd_out,
    output logic [PD_W-1:0] pd_oe_out,
    output logic [PD_W-1:0] pd_fast_slew_out,
    output logic output_macrocell_clk_out,
    output logic auto_power_down_wake_out,
    output logic flash_standby_out,
    output logic flash_select_out
);
`include "lapc_consts.svh"

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    lapc_byte_t pa_lae, pb_lae, pb_hisel, pa_dir, pb_dir, pd_dir;
    lapc_byte_t pa_drv, pb_drv, pd_drv, pa_ptsel, pb_ptsel, pd_ptsel;
    lapc_byte_t pa_peri, pa_data, pb_data, pd_data, pd_func;
    lapc_bus_t bus_state;
    logic [PD_W-1:0] pd_sync1, pd_sync2;
    logic pd_clk_prev;

    lapc_addr_if addr_if ();
    assign addr_if.mux_ad = mux_ad_in;
    assign addr_if.ale = ale_in;

    lapc_addr_latch u_latch (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .bus(addr_if.latch)
    );

    // Latched address enable wins, then peripheral mode, then product term, then direction register
    function automatic lapc_byte_t resolve_oe(lapc_byte_t lae, lapc_byte_t peri, lapc_byte_t peri_oe,
        lapc_byte_t ptsel, lapc_byte_t pt_oe, lapc_byte_t dir);
        lapc_byte_t base;
        base = (peri & peri_oe) | (~peri & ptsel & pt_oe) | (~peri & ~ptsel & dir);
        return lae | (~lae & base);
    endfunction

    // An open-drain pin is released instead of driven high
    function automatic lapc_byte_t drive_oe(lapc_byte_t oe, lapc_byte_t val, lapc_byte_t od);
        return oe & ~(od & val);
    endfunction

    wire lapc_addr_t laddr = addr_if.latched;
    wire lapc_byte_t pd_pt_w = lapc_byte_t'(pd_pt_oe_in);
    wire lapc_byte_t pd_dedicated = {5'h00, pd_func[`LAPC_FUNC_CS], pd_func[`LAPC_FUNC_CLK], 1'b0} &
        8'h06;
    wire lapc_byte_t pa_od = {pa_drv[7:4], 4'h0};
    wire lapc_byte_t pb_od = {pb_drv[7:4], 4'h0};

    wire lapc_byte_t pa_val = (pa_lae & laddr[7:0]) |
        (~pa_lae & ((pa_peri & pa_peri_data_in) | (~pa_peri & pa_data)));
    wire lapc_byte_t pb_addr = (pb_hisel & laddr[15:8]) | (~pb_hisel & laddr[7:0]);
    wire lapc_byte_t pb_val = (pb_lae & pb_addr) | (~pb_lae & pb_data);
    wire lapc_byte_t pd_val = pd_data;

    wire lapc_byte_t pa_oe_res = resolve_oe(pa_lae, pa_peri, pa_peri_oe_in, pa_ptsel, pa_pt_oe_in, pa_dir);
    wire lapc_byte_t pb_oe_res = resolve_oe(pb_lae, 8'h00, 8'h00, pb_ptsel, pb_pt_oe_in, pb_dir);
    wire lapc_byte_t pd_oe_res = resolve_oe(8'h00, 8'h00, 8'h00, pd_ptsel, pd_pt_w, pd_dir) &
        ~pd_dedicated;

    wire lapc_byte_t next_pa_oe = drive_oe(pa_oe_res, pa_val, pa_od);
    wire lapc_byte_t next_pb_oe = drive_oe(pb_oe_res, pb_val, pb_od);
    wire lapc_byte_t next_pd_oe = pd_oe_res;

    // Register bus decode
    wire logic bus_req = avs_read_in | avs_write_in;
    wire logic commit = bus_req & (bus_state == LAPC_BUS_ACK);
    wire logic [5:0] idx = avs_address_in[7:2];
    wire logic aligned = (avs_address_in[1:0] == 2'b00);
    wire logic wr_en = commit & avs_write_in & aligned & avs_byteenable_in[0];
    wire lapc_byte_t wbyte = avs_writedata_in[7:0];

    lapc_byte_t rd_byte;
    always_comb
    begin
        unique case (idx)
            `LAPC_IDX_PA_LAE: rd_byte = pa_lae;
            `LAPC_IDX_PB_LAE: rd_byte = pb_lae;
            `LAPC_IDX_PB_HISEL: rd_byte = pb_hisel;
            `LAPC_IDX_PA_DIR: rd_byte = pa_dir;
            `LAPC_IDX_PB_DIR: rd_byte = pb_dir;
            `LAPC_IDX_PD_DIR: rd_byte = pd_dir;
            `LAPC_IDX_PA_DRV: rd_byte = pa_drv;
            `LAPC_IDX_PB_DRV: rd_byte = pb_drv;
            `LAPC_IDX_PD_DRV: rd_byte = pd_drv;
            `LAPC_IDX_PA_PTSEL: rd_byte = pa_ptsel;
            `LAPC_IDX_PB_PTSEL: rd_byte = pb_ptsel;
            `LAPC_IDX_PD_PTSEL: rd_byte = pd_ptsel;
            `LAPC_IDX_PA_PERI: rd_byte = pa_peri;
            `LAPC_IDX_PA_DATA: rd_byte = pa_data;
            `LAPC_IDX_PB_DATA: rd_byte = pb_data;
            `LAPC_IDX_PD_DATA: rd_byte = pd_data;
            `LAPC_IDX_PA_EO: rd_byte = next_pa_oe;
            `LAPC_IDX_PB_EO: rd_byte = next_pb_oe;
            `LAPC_IDX_PD_EO: rd_byte = next_pd_oe;
            `LAPC_IDX_PD_FUNC: rd_byte = pd_func;
            `LAPC_IDX_LADDR: rd_byte = laddr[7:0];
            default: rd_byte = `LAPC_REG_RST;
        endcase
    end
    wire logic [31:0] next_readdata = aligned ? {24'h000000, rd_byte} : `LAPC_RD_ZERO;

    // One wait cycle, then a single acknowledge cycle
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            bus_state <= LAPC_BUS_IDLE;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= `LAPC_RD_ZERO;
        end
        else
        begin
            bus_state <= (bus_req && bus_state == LAPC_BUS_IDLE) ? LAPC_BUS_ACK : LAPC_BUS_IDLE;
            avs_waitrequest_out <= !(bus_req && bus_state == LAPC_BUS_IDLE);
            if (avs_read_in && bus_state == LAPC_BUS_IDLE)
                avs_readdata_out <= next_readdata;
        end
    end

    // Configuration registers, each one aligned word
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pa_lae <= `LAPC_REG_RST;
            pb_lae <= `LAPC_REG_RST;
            pa_drv <= `LAPC_REG_RST;
            pb_drv <= `LAPC_REG_RST;
            pd_drv <= `LAPC_REG_RST;
            pb_hisel <= `LAPC_REG_RST;
            pa_dir <= `LAPC_REG_RST;
            pb_dir <= `LAPC_REG_RST;
            pd_dir <= `LAPC_REG_RST;
            pa_ptsel <= `LAPC_REG_RST;
            pb_ptsel <= `LAPC_REG_RST;
            pd_ptsel <= `LAPC_REG_RST;
            pa_peri <= `LAPC_REG_RST;
            pa_data <= `LAPC_REG_RST;
            pb_data <= `LAPC_REG_RST;
            pd_data <= `LAPC_REG_RST;
            pd_func <= `LAPC_REG_RST;
        end
        else if (wr_en)
        begin
            unique case (idx)
                `LAPC_IDX_PA_LAE: pa_lae <= wbyte;
                `LAPC_IDX_PB_LAE: pb_lae <= wbyte;
                `LAPC_IDX_PB_HISEL: pb_hisel <= wbyte;
                `LAPC_IDX_PA_DIR: pa_dir <= wbyte;
                `LAPC_IDX_PB_DIR: pb_dir <= wbyte;
                `LAPC_IDX_PD_DIR: pd_dir <= wbyte;
                `LAPC_IDX_PA_DRV: pa_drv <= wbyte;
                `LAPC_IDX_PB_DRV: pb_drv <= wbyte;
                `LAPC_IDX_PD_DRV: pd_drv <= wbyte;
                `LAPC_IDX_PA_PTSEL: pa_ptsel <= wbyte;
                `LAPC_IDX_PB_PTSEL: pb_ptsel <= wbyte;
                `LAPC_IDX_PD_PTSEL: pd_ptsel <= wbyte;
                `LAPC_IDX_PA_PERI: pa_peri <= wbyte;
                `LAPC_IDX_PA_DATA: pa_data <= wbyte;
                `LAPC_IDX_PB_DATA: pb_data <= wbyte;
                `LAPC_IDX_PD_DATA: pd_data <= wbyte;
                `LAPC_IDX_PD_FUNC: pd_func <= wbyte;
                default: ;
            endcase
        end
    end

    // Port D pins come from outside the clock domain
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pd_sync1 <= '0;
            pd_sync2 <= '0;
            pd_clk_prev <= 1'b0;
        end
        else
        begin
            pd_sync1 <= pd_pin_in;
            pd_sync2 <= pd_sync1;
            pd_clk_prev <= pd_sync2[`LAPC_PD_CLK_PIN];
        end
    end

    wire logic clk_fn_on = pd_func[`LAPC_FUNC_CLK];
    wire logic cs_fn_on = pd_func[`LAPC_FUNC_CS];
    wire logic pd_clk_rise = clk_fn_on & pd_sync2[`LAPC_PD_CLK_PIN] & ~pd_clk_prev;
    wire logic cs_deselect = cs_fn_on & pd_sync2[`LAPC_PD_CS_PIN];

    // Registered pin and side outputs
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pa_out <= `LAPC_REG_RST;
            pa_oe_out <= `LAPC_REG_RST;
            pa_fast_slew_out <= `LAPC_REG_RST;
            pb_out <= `LAPC_REG_RST;
            pb_oe_out <= `LAPC_REG_RST;
            pb_fast_slew_out <= `LAPC_REG_RST;
            pd_out <= '0;
            pd_oe_out <= '0;
            pd_fast_slew_out <= '0;
            output_macrocell_clk_out <= 1'b0;
            auto_power_down_wake_out <= 1'b0;
            flash_standby_out <= 1'b0;
            flash_select_out <= 1'b0;
        end
        else
        begin
            pa_out <= pa_val;
            pa_oe_out <= next_pa_oe;
            pa_fast_slew_out <= {4'h0, pa_drv[3:0]};
            pb_out <= pb_val;
            pb_oe_out <= next_pb_oe;
            pb_fast_slew_out <= {4'h0, pb_drv[3:0]};
            pd_out <= pd_val[PD_W-1:0];
            pd_oe_out <= next_pd_oe[PD_W-1:0];
            pd_fast_slew_out <= pd_drv[PD_W-1:0];
            output_macrocell_clk_out <= pd_clk_rise;
            auto_power_down_wake_out <= pd_clk_rise;
            flash_standby_out <= cs_deselect;
            flash_select_out <= flash_select_in & ~cs_deselect;
        end
    end

    sequence wait_then_ack;
        bus_req && avs_waitrequest_out ##1 !avs_waitrequest_out;
    endsequence

    ack_one_cycle_a: assert property (wait_then_ack |=> avs_waitrequest_out)
        else $error("waitrequest low for more than one cycle");

    reset_zero_regs_a: assert property (@(posedge mclk_in) disable iff (1'b0)
        $past(rst_in) && rst_in |-> pa_lae == 8'h00 && pa_drv == 8'h00 && pb_lae == 8'h00)
        else $error("configuration not zero under reset");

    lae_write_a: assert property (wr_en && idx == `LAPC_IDX_PA_LAE |=> pa_lae == $past(wbyte))
        else $error("latched address enable write lost");

    pa_addr_pin_a: assert property (pa_lae != 8'h00
        |=> (pa_out & $past(pa_lae)) == ($past(laddr[7:0]) & $past(pa_lae)))
        else $error("port A pin does not carry address");

    pb_high_byte_a: assert property ((pb_lae & pb_hisel) != 8'h00
        |=> (pb_out & $past(pb_lae) & $past(pb_hisel)) == ($past(laddr[15:8]) & $past(pb_lae) & $past(pb_hisel)))
        else $error("port B high byte missing");

    open_drain_a: assert property (pa_drv[7:4] == 4'hf |=> (pa_oe_out[7:4] & pa_out[7:4]) == 4'h0)
        else $error("open-drain pin driven high");

    eo_readback_a: assert property ((avs_read_in && idx == `LAPC_IDX_PA_EO && aligned) ##0 wait_then_ack
        |-> avs_readdata_out[7:0] == pa_oe_out)
        else $error("enable-out status differs from driver enable");

    peri_oe_a: assert property (pa_lae == 8'h00 && pa_peri != 8'h00 && pa_drv == 8'h00
        |=> (pa_oe_out & $past(pa_peri)) == ($past(pa_peri_oe_in) & $past(pa_peri)))
        else $error("peripheral mode enable not applied");

    cs_standby_a: assert property (cs_fn_on && pd_sync2[`LAPC_PD_CS_PIN]
        |=> flash_standby_out && !flash_select_out)
        else $error("chip select high did not force standby");

    macrocell_clk_a: assert property (output_macrocell_clk_out
        |-> $past(clk_fn_on) ##1 !output_macrocell_clk_out)
        else $error("macrocell clock without clock function");
endmodule
`default_nettype wire
